// ### serial_dac_input_logic.sv
// Digital input path of a 12-bit serial DAC with an APB register slave.
//
// Summary of operation
// - Serial-in shift register under chain, sync, clock.
// - Complete word moves to DAC latch on strobe.
// - Converter code comes only from the latch.
// - Latch and converter code are twelve bits.
// - Load strobe falling edge updates the latch.
// - Strobe held low in standalone mode: load on sixteenth fall.
// - Chain-enable level picks standalone or chain mode.
// - Chain mode drives serial out, shifts each fall while sync is low.
// - Standalone takes sixteen bits, then gates clock.
// - Four ignored bits, twelve code bits MSB first.
// - Clear input low forces latch to zeros.
`default_nettype none
`include "dac_input_defs.svh"
module serial_dac_input_logic (
    input  wire logic                  clk,                 // 10 MHz clock
    input  wire logic                  reset_n,             // Async reset
    input  wire logic                  serialClock,         // Link clock pin
    input  wire logic                  frameSync_n,         // Frame sync
    input  wire logic                  serial_word_in,      // Serial data
    input  wire logic                  latch_load_strobe_n, // Load strobe
    input  wire logic                  chain_mode_select,   // Chain enable
    input  wire logic                  latch_zero_n,        // Clear input
    output logic                       chained_serial_out,  // Chain data
    output logic                       chainedOutEnable,    // Drives pin
    output logic [`CODE_BITS-1:0]      dacCode,             // Converter code
    input  wire logic                  psel,                // APB select
    input  wire logic                  penable,             // APB enable
    input  wire logic                  pwrite,              // APB direction
    input  wire logic [`ADDR_BITS-1:0] paddr,               // APB address
    input  wire logic [31:0]           pwdata,              // APB write data
    input  wire logic [3:0]            pstrb,               // APB strobes
    output logic [31:0]                prdata,              // APB read data
    output logic                       pready,              // APB ready
    output logic                       pslverr              // APB error
);
    import dac_input_pkg::*;

    // ****************************************
    // Pin synchronisation and edge detection
    // ****************************************
    pin_bundle_type rawPins;
    pin_bundle_type pins;
    pin_bundle_type prevPins;

    always_comb begin
        rawPins.serialClock  = serialClock;
        rawPins.frameSync_n  = frameSync_n;
        rawPins.serialWordIn = serial_word_in;
        rawPins.loadStrobe_n = latch_load_strobe_n;
        rawPins.chainMode    = chain_mode_select;
        rawPins.zero_n       = latch_zero_n;
    end

    pin_sync u_pin_sync (
        .clk        (clk),
        .reset_n    (reset_n),
        .rawPins    (rawPins),
        .stablePins (pins)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevPins <= `PIN_REST;
        end else begin
            prevPins <= pins;
        end
    end

    logic sclkFall;
    logic strobeFall;
    assign sclkFall   = prevPins.serialClock & ~pins.serialClock;
    assign strobeFall = prevPins.loadStrobe_n & ~pins.loadStrobe_n;

    // ****************************************
    // Frame control and shift register
    // ****************************************
    frame_state_type       frameState;
    frame_state_type       next_frameState;
    logic [15:0]           shiftWord;
    logic [15:0]           next_shiftWord;
    logic [4:0]            bitCount;
    logic [4:0]            next_bitCount;
    logic                  autoMode;
    logic                  next_autoMode;
    logic [`CODE_BITS-1:0] latchCode;
    logic [`CODE_BITS-1:0] next_latchCode;
    logic                  next_chainedOut;
    logic                  softZero;
    logic                  next_softZero;
    logic                  startFrame;
    logic                  shiftEn;
    logic                  lastBit;
    logic                  zeroReq;
    logic [4:0]            baseCount;

    assign startFrame = (frameState == FRAME_IDLE) & ~pins.frameSync_n;
    assign baseCount  = startFrame ? 5'd0 : bitCount;
    assign shiftEn = sclkFall & ~pins.frameSync_n
                   & (pins.chainMode | startFrame
                      | (frameState == FRAME_SHIFT));
    assign lastBit = shiftEn & ~pins.chainMode
                   & (baseCount == `FRAME_LAST_BIT);
    assign zeroReq = ~pins.zero_n | softZero;

    always_comb begin
        next_frameState = frameState;
        next_bitCount   = startFrame ? 5'd0 : bitCount;
        next_autoMode   = autoMode;
        next_shiftWord  = shiftWord;
        next_latchCode  = latchCode;
        if (startFrame) begin
            next_autoMode = ~pins.loadStrobe_n;
        end
        unique case (frameState)
            FRAME_IDLE: begin
                if (!pins.frameSync_n) begin
                    next_frameState = lastBit ? FRAME_FULL : FRAME_SHIFT;
                end
            end
            FRAME_SHIFT: begin
                if (pins.frameSync_n) begin
                    next_frameState = FRAME_IDLE;
                end else if (lastBit) begin
                    next_frameState = FRAME_FULL;
                end
            end
            FRAME_FULL: begin
                if (pins.frameSync_n) begin
                    next_frameState = FRAME_IDLE;
                end
            end
            default: begin
                next_frameState = FRAME_IDLE;
            end
        endcase
        if (shiftEn) begin
            next_shiftWord = {shiftWord[14:0], pins.serialWordIn};
            if (baseCount != `FRAME_BITS) begin
                next_bitCount = baseCount + 5'd1;
            end
        end
        if (zeroReq) begin
            next_latchCode = `CODE_ZERO;
        end else if (strobeFall) begin
            next_latchCode = shiftWord[`CODE_BITS-1:0];
        end else if (lastBit && next_autoMode) begin
            next_latchCode = next_shiftWord[`CODE_BITS-1:0];
        end
        next_chainedOut = pins.chainMode & next_shiftWord[15];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frameState         <= FRAME_IDLE;
            shiftWord          <= 16'h0000;
            bitCount           <= 5'h00;
            autoMode           <= 1'b0;
            latchCode          <= `CODE_ZERO;
            chained_serial_out <= 1'b0;
            chainedOutEnable   <= 1'b0;
        end else begin
            frameState         <= next_frameState;
            shiftWord          <= next_shiftWord;
            bitCount           <= next_bitCount;
            autoMode           <= next_autoMode;
            latchCode          <= next_latchCode;
            chained_serial_out <= next_chainedOut;
            chainedOutEnable   <= pins.chainMode;
        end
    end

    assign dacCode = latchCode;

    // ****************************************
    // APB register slave
    // ****************************************
    logic        setupPhase;
    logic        accessDone;
    logic [31:0] readValue;
    logic        mapped;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;

    always_comb begin
        readValue = `READ_ZERO;
        mapped    = 1'b1;
        unique case (paddr)
            `CTRL_OFFSET: begin
                readValue[`CTRL_ZERO_BIT] = softZero;
            end
            `STATUS_OFFSET: begin
                readValue[`CODE_BITS-1:0]       = latchCode;
                readValue[`STAT_CHAIN_BIT]      = pins.chainMode;
                readValue[`STAT_AUTO_BIT]       = autoMode;
                readValue[`STAT_BUSY_BIT]       = frameState == FRAME_SHIFT;
                readValue[`STAT_FULL_BIT]       = frameState == FRAME_FULL;
                readValue[`STAT_COUNT_LSB +: 5] = bitCount;
            end
            `SHIFT_OFFSET: begin
                readValue[15:0] = shiftWord;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        next_pready   = setupPhase;
        next_pslverr  = setupPhase & ~mapped;
        next_prdata   = (setupPhase & ~pwrite) ? readValue : `READ_ZERO;
        next_softZero = softZero;
        if (accessDone && pwrite && mapped && pstrb[0]
            && (paddr == `CTRL_OFFSET)) begin
            next_softZero = pwdata[`CTRL_ZERO_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata   <= `READ_ZERO;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            softZero <= `CTRL_RESET;
        end else begin
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
            softZero <= next_softZero;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_last_bit_auto;
        lastBit && autoMode && !startFrame && !zeroReq && !strobeFall;
    endsequence

    sequence s_strobe_load;
        strobeFall && !zeroReq;
    endsequence

    a_shift_entry: assert property (
        shiftEn |=> shiftWord[0] == $past(pins.serialWordIn)
                    && shiftWord[15:1] == $past(shiftWord[14:0]))
        else $error("Shift register did not take the serial bit.");

    a_strobe_load: assert property (
        s_strobe_load |=> latchCode == $past(shiftWord[11:0]))
        else $error("Strobe edge did not load the latch.");

    a_complete_word: assert property (
        (bitCount == `FRAME_BITS) ##1 s_strobe_load
            |=> dacCode == $past(shiftWord[11:0]))
        else $error("Complete word not moved to the latch.");

    a_latch_hold: assert property (
        !(zeroReq || strobeFall || lastBit) |=> $stable(dacCode))
        else $error("Converter code changed without a transfer.");

    a_auto_update: assert property (
        s_last_bit_auto |=> latchCode[0] == $past(pins.serialWordIn)
                            && frameState == FRAME_FULL)
        else $error("Automatic update missed the sixteenth edge.");

    a_code_order: assert property (
        s_last_bit_auto |=> latchCode[11:1] == $past(shiftWord[10:0]))
        else $error("Latch did not get the last twelve bits.");

    a_mode_select: assert property (
        pins.chainMode |=> chainedOutEnable ##1
            (frameState != FRAME_FULL || $past(frameState) == FRAME_FULL))
        else $error("Chain mode did not enable the output.");

    a_chain_out: assert property (
        shiftEn && pins.chainMode |=> chained_serial_out == shiftWord[15])
        else $error("Chained output does not follow the register.");

    a_gate_closed: assert property (
        frameState == FRAME_FULL && sclkFall
            |-> bitCount == `FRAME_BITS ##1 $stable(shiftWord))
        else $error("Clock not gated after sixteen bits.");

    a_zero_force: assert property (
        !pins.zero_n |=> dacCode == `CODE_ZERO [*2])
        else $error("Clear did not hold the latch at zero.");

    a_apb_answer: assert property (
        setupPhase |=> pready ##1 !pready)
        else $error("APB ready is not a single cycle answer.");

endmodule
`default_nettype wire

// ### dac_input_defs.svh
// Constants for the serial DAC input logic: offsets, fields, resets, counts.
`ifndef DAC_INPUT_DEFS_SVH
`define DAC_INPUT_DEFS_SVH

// ****************************************
// Frame and code layout
// ****************************************
`define FRAME_BITS        5'd16
`define FRAME_LAST_BIT    5'd15
`define CODE_BITS         12
`define CODE_ZERO         12'h000

// ****************************************
// Register map (byte addresses)
// ****************************************
`define ADDR_BITS         12
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define SHIFT_OFFSET      12'h008
`define CTRL_RESET        1'b0
`define CTRL_ZERO_BIT     0
`define STAT_CHAIN_BIT    16
`define STAT_AUTO_BIT     17
`define STAT_BUSY_BIT     18
`define STAT_FULL_BIT     19
`define STAT_COUNT_LSB    20
`define READ_ZERO         32'h0000_0000

// ****************************************
// Pin resting levels, order as the pin bundle
// ****************************************
`define PIN_REST          6'h35

`endif

// ### dac_input_pkg.sv
// Types shared by the serial DAC input logic.
`default_nettype none
package dac_input_pkg;

    typedef struct packed {
        logic serialClock;
        logic frameSync_n;
        logic serialWordIn;
        logic loadStrobe_n;
        logic chainMode;
        logic zero_n;
    } pin_bundle_type;

    typedef enum logic [2:0] {
        FRAME_IDLE  = 3'b001,
        FRAME_SHIFT = 3'b010,
        FRAME_FULL  = 3'b100
    } frame_state_type;

endpackage
`default_nettype wire

// ### pin_sync.sv
// Three-stage synchroniser with agreement filter for the input pins.
`default_nettype none
`include "dac_input_defs.svh"
module pin_sync (
    input  wire logic                           clk,        // System clock
    input  wire logic                           reset_n,    // Async reset
    input  wire dac_input_pkg::pin_bundle_type  rawPins,    // Pin levels
    output var  dac_input_pkg::pin_bundle_type  stablePins  // Filtered
);
    import dac_input_pkg::*;

    logic [5:0] stage1;
    logic [5:0] stage2;
    logic [5:0] stage3;
    logic [5:0] level;
    logic [5:0] next_level;

    // A level is taken over only once the second and third stages agree.
    always_comb begin
        next_level = ((stage2 ~^ stage3) & stage3)
                   | ((stage2 ^ stage3) & level);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= `PIN_REST;
            stage2 <= `PIN_REST;
            stage3 <= `PIN_REST;
            level  <= `PIN_REST;
        end else begin
            stage1 <= rawPins;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

    assign stablePins = level;

endmodule
`default_nettype wire

// ### host_serial_model.sv
// Host serial port model driving frames into the DAC input pins.
`default_nettype none
module host_serial_model (
    input  wire logic clk,          // System clock
    output var  logic serialClock,  // Link clock, rests high
    output var  logic frameSync_n,  // Frame sync, active low
    output var  logic serialWordIn  // Serial data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serialClock  = 1'b1;
        frameSync_n  = 1'b1;
        serialWordIn = 1'b0;
    end

    // MSB first, sync spans the frame
    task automatic send(input logic [31:0] word, input int nBits);
        int i;
        @(posedge clk);
        frameSync_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (i = nBits - 1; i >= 0; i--) begin
            serialWordIn <= word[i];
            repeat (2) @(posedge clk);
            serialClock <= 1'b0;
            repeat (4) @(posedge clk);
            serialClock <= 1'b1;
            repeat (2) @(posedge clk);
        end
        repeat (2) @(posedge clk);
        frameSync_n  <= 1'b1;
        serialWordIn <= ~serialWordIn;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### serial_dac_input_logic_tb.sv
// Self-checking bench for the serial DAC input logic.
`default_nettype none
`include "dac_input_defs.svh"
module serial_dac_input_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        reset_n;
    wire logic   serialClock;
    wire logic   frameSync_n;
    wire logic   serial_word_in;
    logic        latch_load_strobe_n;
    logic        chain_mode_select;
    logic        latch_zero_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    wire logic   chained_serial_out;
    wire logic   chainedOutEnable;
    wire logic [11:0] dacCode;
    wire logic [31:0] prdata;
    wire logic   pready;
    wire logic   pslverr;
    int          n_fail;
    int          num_checks;
    int          cycles;
    logic [31:0] rd;
    logic        err;

    host_serial_model u_host (
        .clk          (clk),
        .serialClock  (serialClock),
        .frameSync_n  (frameSync_n),
        .serialWordIn (serial_word_in)
    );

    serial_dac_input_logic u_dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .serialClock         (serialClock),
        .frameSync_n         (frameSync_n),
        .serial_word_in      (serial_word_in),
        .latch_load_strobe_n (latch_load_strobe_n),
        .chain_mode_select   (chain_mode_select),
        .latch_zero_n        (latch_zero_n),
        .chained_serial_out  (chained_serial_out),
        .chainedOutEnable    (chainedOutEnable),
        .dacCode             (dacCode),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .pstrb               (pstrb),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, expected, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wdata);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        check("apbWait", k, 32'd1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [11:0] addr,
                         input logic [31:0] expected);
        apb(1'b0, addr, 32'h0000_0000);
        check(name, rd, expected);
    endtask

    task automatic load_pulse;
        latch_load_strobe_n <= 1'b0;
        repeat (5) @(posedge clk);
        latch_load_strobe_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    initial begin
        reset_n             = 1'b0;
        latch_load_strobe_n = 1'b1;
        chain_mode_select   = 1'b0;
        latch_zero_n        = 1'b1;
        psel                = 1'b0;
        penable             = 1'b0;
        pwrite              = 1'b0;
        paddr               = 12'h000;
        pwdata              = 32'h0000_0000;
        pstrb               = 4'hF;
        n_fail              = 0;
        num_checks          = 0;
        cycles              = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'h0);
        check("outEnable", chainedOutEnable, 32'h0);
        rdchk("ctrl", `CTRL_OFFSET, 32'h0);
        u_host.send(32'h0000_A5C3, 16);
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'h0);
        rdchk("shift", `SHIFT_OFFSET, 32'h0000_A5C3);
        load_pulse();
        check("dacCode", dacCode, 32'h5C3);
        u_host.send(32'h0001_2345, 20);
        rdchk("shift", `SHIFT_OFFSET, 32'h0000_1234);
        load_pulse();
        check("dacCode", dacCode, 32'h234);
        latch_load_strobe_n <= 1'b0;
        u_host.send(32'h0000_FABC, 16);
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'hABC);
        rdchk("status", `STATUS_OFFSET, 32'h0102_0ABC);
        latch_load_strobe_n <= 1'b1;
        latch_zero_n <= 1'b0;
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'h0);
        latch_zero_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'h0);
        load_pulse();
        check("dacCode", dacCode, 32'hABC);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0001);
        repeat (10) @(posedge clk);
        check("dacCode", dacCode, 32'h0);
        rdchk("ctrl", `CTRL_OFFSET, 32'h1);
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0000);
        pstrb <= 4'h0;
        apb(1'b1, `CTRL_OFFSET, 32'h0000_0001);
        pstrb <= 4'hF;
        rdchk("ctrlStrb", `CTRL_OFFSET, 32'h0);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("errUnmapped", {31'd0, err}, 32'h1);
        check("rdUnmapped", rd, 32'h0);
        // chain enable raised only for a cascade
        chain_mode_select <= 1'b1;
        repeat (10) @(posedge clk);
        check("outEnable", chainedOutEnable, 32'h1);
        u_host.send(32'h1234_8765, 32);
        rdchk("shift", `SHIFT_OFFSET, 32'h0000_8765);
        rdchk("status", `STATUS_OFFSET, 32'h0101_0000);
        check("chainOut", chained_serial_out, 32'h1);
        check("dacCode", dacCode, 32'h0);
        load_pulse();
        check("dacCode", dacCode, 32'h765);
        chain_mode_select <= 1'b0;
        repeat (10) @(posedge clk);
        check("outEnable", chainedOutEnable, 32'h0);
        check("chainOut", chained_serial_out, 32'h0);
        results();
    end
endmodule
`default_nettype wire
